// ### rtl/sas_regs.svh
// Summary of operation
// - Each selected input is resolved by successive approximation into a 10-bit result.
// - Channel select at control_a bits 4:2 routes one of eight inputs to sampling.
// - Two reference bits pick positive supply/pin and negative ground/pin independently.
// - One conversion ends on the 11th conversion-clock tick after start; the divider is not restarted, so this is 10 to 11 periods.
// - control_b bits 6:4 pick /2,/4,/8,/16,/32,/64 or the dedicated RC clock.
// - Writing one to start/busy begins a conversion; it reads one while converting.
// - Completion clears start/busy, sets done flag bit 6, raises enabled interrupt.
// - Clearing start/busy mid-conversion aborts; result registers keep the previous value.
// - After abort, wait 2 conversion-clock ticks (1 to 2 periods), then acquire the selected channel again.
// - Each analog-select bit disables the digital input buffer of its pin.
// - control_a bit 7 picks justification: one right, zero left.
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH

`define SAS_OFS_CTRL_A      8'h00
`define SAS_OFS_CTRL_B      8'h04
`define SAS_OFS_PIN_SEL     8'h08
`define SAS_OFS_RES_HIGH    8'h0c
`define SAS_OFS_RES_LOW     8'h10
`define SAS_OFS_FLAGS       8'h14
`define SAS_OFS_MASK        8'h18

`define SAS_CA_ENABLE       0
`define SAS_CA_GO           1
`define SAS_CA_CHAN_LO      2
`define SAS_CA_CHAN_HI      4
`define SAS_CA_VREF_POS     5
`define SAS_CA_VREF_NEG     6
`define SAS_CA_JUSTIFY      7
`define SAS_CB_CLK_LO       4
`define SAS_CB_CLK_HI       6
`define SAS_FLAG_DONE       6

`define SAS_PIN_SEL_RESET   8'hff
`define SAS_RES_BITS        10
`define SAS_CONV_TADS       11
`define SAS_ABORT_TADS      2
`define SAS_CLK_RC          2'b11

`endif

// ### rtl/sas_pkg.sv
package sas_pkg;
  typedef enum logic [1:0] {SAS_IDLE, SAS_CONV, SAS_RECOVER} sas_state_e;
  typedef logic [9:0] sas_code_t;
endpackage

// ### rtl/sas_conv_if.sv
`timescale 1ns/10ps
interface sas_conv_if;
  logic              enable;
  logic              go;
  logic              tad_tick;
  logic              cmp_high;
  logic              done;
  logic              busy;
  logic              acquire;
  sas_pkg::sas_code_t result;
  sas_pkg::sas_code_t dac_code;

  modport ctl (output enable, go, tad_tick, cmp_high,
               input  done, busy, acquire, result, dac_code);
  modport seq (input  enable, go, tad_tick, cmp_high,
               output done, busy, acquire, result, dac_code);
endinterface

// ### rtl/sas_clkdiv.sv
`timescale 1ns/10ps
`include "sas_regs.svh"
module sas_clkdiv
#(
  parameter int CNT_W = 6
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [2:0] clk_sel,
  input  wire logic       rc_osc,
  output logic            tad_tick
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;
  logic             rc_s1;
  logic             rc_s2;
  logic             rc_s3;
  logic             use_rc;

  generate
    if (CNT_W < 6)
    begin : g_chk
      $error("sas_clkdiv needs at least 6 counter bits for divide by 64");
    end
  endgenerate

  // 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64
  function automatic logic [CNT_W-1:0] div_limit(input logic [2:0] sel);
    logic [2:0] expo;
    expo = {sel[1:0], 1'b0} + {2'b00, sel[2]} + 3'd1;
    div_limit = CNT_W'((7'd1 << expo) - 7'd1);
  endfunction

  assign use_rc = (clk_sel[1:0] == `SAS_CLK_RC);
  assign limit  = div_limit(clk_sel);

  // Oscillator pin passes two flops before the edge detector sees it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end
    else
    begin
      rc_s1 <= rc_osc;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt      <= '0;
      tad_tick <= 1'b0;
    end
    else if (!enable)
    begin
      cnt      <= '0;
      tad_tick <= 1'b0;
    end
    else if (use_rc)
    begin
      cnt      <= '0;
      tad_tick <= rc_s2 & ~rc_s3;
    end
    else if (cnt >= limit)
    begin
      cnt      <= '0;
      tad_tick <= 1'b1;
    end
    else
    begin
      cnt      <= cnt + CNT_W'(1);
      tad_tick <= 1'b0;
    end
  end
endmodule

// ### rtl/sas_sar.sv
`timescale 1ns/10ps
`include "sas_regs.svh"
module sas_sar
#(
  parameter int RES_BITS = 10
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  sas_conv_if.seq   cif
);
  sas_pkg::sas_state_e state;
  logic [3:0]          cnt;
  sas_pkg::sas_code_t  bitpos;

  generate
    if (RES_BITS != `SAS_RES_BITS)
    begin : g_chk
      $error("sas_sar supports a 10-bit result only");
    end
  endgenerate

  assign bitpos  = 10'h200 >> cnt;
  assign cif.busy = (state != sas_pkg::SAS_IDLE);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= sas_pkg::SAS_IDLE;
      cnt          <= 4'h0;
      cif.dac_code <= 10'h000;
      cif.result   <= 10'h000;
      cif.done     <= 1'b0;
      cif.acquire  <= 1'b0;
    end
    else
    begin
      cif.done <= 1'b0;
      case (state)
        sas_pkg::SAS_IDLE:
        begin
          cif.acquire <= cif.enable;
          if (cif.enable && cif.go && !cif.done)
          begin
            state        <= sas_pkg::SAS_CONV;
            cnt          <= 4'h0;
            cif.dac_code <= 10'h200;
            cif.acquire  <= 1'b0;
          end
        end
        sas_pkg::SAS_CONV:
        begin
          if (!cif.go || !cif.enable)
          begin
            state <= sas_pkg::SAS_RECOVER;
            cnt   <= 4'h0;
          end
          else if (cif.tad_tick)
          begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'(`SAS_CONV_TADS - 1))
            begin
              cif.result <= cif.dac_code;
              cif.done   <= 1'b1;
              state      <= sas_pkg::SAS_IDLE;
            end
            else if (cif.cmp_high)
            begin
              cif.dac_code <= cif.dac_code | (bitpos >> 1);
            end
            else
            begin
              cif.dac_code <= (cif.dac_code & ~bitpos) | (bitpos >> 1);
            end
          end
        end
        sas_pkg::SAS_RECOVER:
        begin
          if (cif.tad_tick)
          begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'(`SAS_ABORT_TADS - 1))
            begin
              state <= sas_pkg::SAS_IDLE;
            end
          end
        end
        default:
        begin
          state <= sas_pkg::SAS_IDLE;
        end
      endcase
    end
  end
endmodule

// ### rtl/sas_top.sv
`timescale 1ns/10ps
`include "sas_regs.svh"
module sas_top
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmp_high,
  input  wire logic        rc_osc,
  output logic [2:0]       channel_select,
  output logic             vref_pos_ext,
  output logic             vref_neg_ext,
  output logic             sample_hold,
  output logic [9:0]       dac_code,
  output logic [7:0]       digital_in_disable,
  output logic             irq
);
  logic        rst_s1;
  logic        rst_n;
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        wr_fire;
  logic        wr_lane0;
  logic [7:0]  wb;
  logic        rd_fire;
  logic [31:0] next_rdata;
  logic        next_rok;

  logic        result_justify;
  logic [1:0]  reference_select;
  logic        conv_enable;
  logic        go;
  logic [2:0]  conv_clock_select;
  logic [7:0]  analog_select_bits;
  logic        conv_done_flag;
  logic        done_mask;
  logic [7:0]  result_high;
  logic [7:0]  result_low;

  sas_conv_if cif ();

  // Reset enters asynchronously but is released through two flops
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  sas_clkdiv u_div
  (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .enable   (conv_enable),
    .clk_sel  (conv_clock_select),
    .rc_osc   (rc_osc),
    .tad_tick (cif.tad_tick)
  );

  sas_sar u_sar
  (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .cif   (cif.seq)
  );

  assign cif.enable   = conv_enable;
  assign cif.go       = go;
  assign cif.cmp_high = cmp_high;

  // Trial code leaves the sequencer flop directly so the comparator settles before a tick
  assign dac_code = cif.dac_code;

  // Write channel: address and data are taken in either order
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && w_strb[0];
  assign wb       = w_data[7:0];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      w_held        <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[1:0] == 2'b00 && aw_addr <= `SAS_OFS_MASK) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_justify     <= 1'b0;
      reference_select   <= 2'b00;
      channel_select     <= 3'h0;
      conv_enable        <= 1'b0;
      conv_clock_select  <= 3'h0;
      analog_select_bits <= `SAS_PIN_SEL_RESET;
      done_mask          <= 1'b0;
    end
    else if (wr_lane0)
    begin
      case (aw_addr)
        `SAS_OFS_CTRL_A:
        begin
          result_justify   <= wb[`SAS_CA_JUSTIFY];
          reference_select <= {wb[`SAS_CA_VREF_NEG], wb[`SAS_CA_VREF_POS]};
          channel_select   <= wb[`SAS_CA_CHAN_HI:`SAS_CA_CHAN_LO];
          conv_enable      <= wb[`SAS_CA_ENABLE];
        end
        `SAS_OFS_CTRL_B: conv_clock_select <= wb[`SAS_CB_CLK_HI:`SAS_CB_CLK_LO];
        `SAS_OFS_PIN_SEL: analog_select_bits <= wb;
        `SAS_OFS_MASK: done_mask <= wb[`SAS_FLAG_DONE];
        default: ;
      endcase
    end
  end

  // Start/busy bit; a start written together with the enable is ignored
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      go <= 1'b0;
    end
    else if (wr_lane0 && aw_addr == `SAS_OFS_CTRL_A)
    begin
      go <= wb[`SAS_CA_GO] && wb[`SAS_CA_ENABLE] && conv_enable;
    end
    else if (cif.done || !conv_enable)
    begin
      go <= 1'b0;
    end
  end

  // Done flag: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_done_flag <= 1'b0;
    end
    else if (cif.done)
    begin
      conv_done_flag <= 1'b1;
    end
    else if (wr_lane0 && aw_addr == `SAS_OFS_FLAGS && wb[`SAS_FLAG_DONE])
    begin
      conv_done_flag <= 1'b0;
    end
  end

  // Result pair only moves on completion, so an abort keeps the old value
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_high <= 8'h00;
      result_low  <= 8'h00;
    end
    else if (cif.done)
    begin
      if (result_justify)
      begin
        result_high <= {6'h00, cif.result[9:8]};
        result_low  <= cif.result[7:0];
      end
      else
      begin
        result_high <= cif.result[9:2];
        result_low  <= {cif.result[1:0], 6'h00};
      end
    end
  end

  // Pin-facing outputs, all registered
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vref_pos_ext       <= 1'b0;
      vref_neg_ext       <= 1'b0;
      sample_hold        <= 1'b0;
      digital_in_disable <= `SAS_PIN_SEL_RESET;
      irq                <= 1'b0;
    end
    else
    begin
      vref_pos_ext       <= reference_select[0];
      vref_neg_ext       <= reference_select[1];
      sample_hold        <= cif.acquire;
      digital_in_disable <= analog_select_bits;
      irq                <= conv_done_flag && done_mask;
    end
  end

  // Read channel
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rok   = 1'b1;
    case (s_axi_araddr)
      `SAS_OFS_CTRL_A:
      begin
        next_rdata[7:0] = {result_justify, reference_select, channel_select,
                           go, conv_enable};
      end
      `SAS_OFS_CTRL_B:   next_rdata[`SAS_CB_CLK_HI:`SAS_CB_CLK_LO] = conv_clock_select;
      `SAS_OFS_PIN_SEL:  next_rdata[7:0] = analog_select_bits;
      `SAS_OFS_RES_HIGH: next_rdata[7:0] = result_high;
      `SAS_OFS_RES_LOW:  next_rdata[7:0] = result_low;
      `SAS_OFS_FLAGS:    next_rdata[`SAS_FLAG_DONE] = conv_done_flag;
      `SAS_OFS_MASK:     next_rdata[`SAS_FLAG_DONE] = done_mask;
      default:           next_rok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### tb/sas_props.sv
`timescale 1ns/10ps
module sas_props
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sample_hold,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
                                   |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
                                   |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  chk_hold_low: assert property ($fell(sample_hold) |-> !sample_hold [*4])
    else $error("acquisition resumed too soon");
  chk_irq_clear: assert property ($fell(irq) |-> $past(s_axi_bvalid)
                                  || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("interrupt fell without a write");
endmodule

// ### tb/sas_afe_model.sv
`timescale 1ns/10ps
module sas_afe
(
  input wire logic [2:0] channel_select,
  input wire logic       sample_hold,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] level [8],
  output logic           cmp_high,
  output logic           rc_osc
);
  logic [9:0] held;
  // Capacitor tracks the selected pin only while connected
  always @* if (sample_hold) held = level[channel_select];
  // Ideal comparator; any trial order works, the design must go MSB first
  assign cmp_high = held >= dac_code;
  // RC oscillator runs free with a period near 2 us
  initial rc_osc = 1'b0;
  always #1001 rc_osc = ~rc_osc;
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
`include "sas_regs.svh"
module tb;
  logic        ref_clk = 0, nrst = 0;
  logic [7:0]  aa = 0, ra = 0;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0]  ws = 4'hf;
  logic        awr, wr_, bv, arr, rv, sh, irq, vp, vn, cmp, rco;
  logic [1:0]  br, rr;
  logic [2:0]  cs;
  logic [9:0]  dac;
  logic [7:0]  did;
  logic [9:0]  level [8];
  int          err_count = 0, tests_run = 0, low_run = 0, last_low = 0;
  localparam logic [2:0] SELS [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  localparam int DIVS [8] = '{2, 4, 8, 16, 32, 64, 200, 200};

  sas_top sas_top_i (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .cmp_high(cmp), .rc_osc(rco),
    .channel_select(cs), .vref_pos_ext(vp), .vref_neg_ext(vn), .sample_hold(sh),
    .dac_code(dac), .digital_in_disable(did), .irq(irq));
  sas_afe sas_afe_i (.channel_select(cs), .sample_hold(sh), .dac_code(dac), .level(level),
    .cmp_high(cmp), .rc_osc(rco));

  always #5 ref_clk = ~ref_clk;
  // Length of the last low stretch of sample_hold
  always @(posedge ref_clk)
  begin
    low_run <= sh ? 0 : low_run + 1;
    if (sh && low_run != 0) last_low <= low_run;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge ref_clk);
    aa  <= a;
    awv <= 1;
    wd  <= d;
    wv  <= 1;
    bry <= 1;
    while (!(ad && dd))
    begin
      @(posedge ref_clk);
      if (awv && awr)
      begin
        ad = 1;
        awv <= 0;
      end
      if (wv && wr_)
      begin
        dd = 1;
        wv <= 0;
      end
    end
    while (!bv) @(posedge ref_clk);
    r = br;
    bry <= 0;
  endtask
  task w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    ra  <= a;
    arv <= 1;
    rry <= 1;
    @(posedge ref_clk);
    while (!arr) @(posedge ref_clk);
    arv <= 0;
    while (!rv) @(posedge ref_clk);
    d = rd;
    r = rr;
    rry <= 0;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rdr(a, d, r);
    chk(nm, d, exp);
  endtask
  task settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task t_reset;
    rchk("ctrl_a", `SAS_OFS_CTRL_A, 32'h0);
    rchk("pin_sel", `SAS_OFS_PIN_SEL, 32'hff);
    chk("din_dis", did, 8'hff);
    rchk("flags", `SAS_OFS_FLAGS, 32'h0);
    w(`SAS_OFS_PIN_SEL, 32'h5a);
    settle(2);
    chk("din_dis", did, 8'h5a);
  endtask
  task t_fields;
    for (int i = 0; i < 8; i++)
    begin
      w(`SAS_OFS_CTRL_A, {24'h0, 1'b0, i[1], i[0], i[2:0], 2'h1});
      settle(2);
      chk("chan", cs, i[2:0]);
      chk("vref", {vn, vp}, i[1:0]);
    end
    w(`SAS_OFS_CTRL_A, 32'h0);
    w(`SAS_OFS_CTRL_A, 32'h3);
    rchk("go_ignored", `SAS_OFS_CTRL_A, 32'h1);
  endtask
  task t_conv(input int k);
    logic [2:0]  ch;
    logic        j;
    logic [31:0] ca;
    logic [31:0] exp_hi;
    logic [31:0] exp_lo;
    int          lo_lim;
    int          hi_lim;
    ch = k[2:0];
    j = k[0];
    ca = {24'h0, j, 2'h0, ch, 2'h1};
    exp_hi = j ? {30'h0, level[k][9:8]} : {24'h0, level[k][9:2]};
    exp_lo = j ? {24'h0, level[k][7:0]} : {24'h0, level[k][1:0], 6'h0};
    lo_lim = 10 * DIVS[k];
    hi_lim = 11 * DIVS[k] + DIVS[k] / 8 + 4;
    w(`SAS_OFS_FLAGS, 32'h40);
    w(`SAS_OFS_CTRL_B, {25'h0, SELS[k], 4'h0});
    w(`SAS_OFS_CTRL_A, ca);
    w(`SAS_OFS_CTRL_A, ca | 32'h2);
    rchk("busy", `SAS_OFS_CTRL_A, ca | 32'h2);
    while (!sh) @(posedge ref_clk);
    settle(2);
    chk("conv_len", last_low >= lo_lim && last_low <= hi_lim, 1);
    rchk("busy_clr", `SAS_OFS_CTRL_A, ca);
    rchk("flags", `SAS_OFS_FLAGS, 32'h40);
    chk("irq_masked", irq, 1'b0);
    rchk("res_high", `SAS_OFS_RES_HIGH, exp_hi);
    rchk("res_low", `SAS_OFS_RES_LOW, exp_lo);
  endtask
  task t_irq;
    w(`SAS_OFS_MASK, 32'h40);
    settle(2);
    chk("irq_on", irq, 1'b1);
    w(`SAS_OFS_MASK, 32'h0);
    settle(2);
    chk("irq_mask", irq, 1'b0);
    w(`SAS_OFS_MASK, 32'h40);
    w(`SAS_OFS_FLAGS, 32'h40);
    settle(2);
    chk("irq_clr", irq, 1'b0);
    rchk("flags_clr", `SAS_OFS_FLAGS, 32'h0);
  endtask
  // Starts from the right-justified result of channel 7 left by the last conversion
  task t_abort;
    int n;
    n = 0;
    w(`SAS_OFS_CTRL_B, 32'h60);
    w(`SAS_OFS_CTRL_A, 32'h8d);
    w(`SAS_OFS_CTRL_A, 32'h8f);
    settle(20);
    w(`SAS_OFS_CTRL_A, 32'h8d);
    while (!sh && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("recover", n >= 60 && n <= 132, 1);
    chk("reacq_chan", cs, 3'h3);
    rchk("res_high", `SAS_OFS_RES_HIGH, {30'h0, level[7][9:8]});
    rchk("res_low", `SAS_OFS_RES_LOW, {24'h0, level[7][7:0]});
    rchk("no_flag", `SAS_OFS_FLAGS, 32'h0);
    chk("no_irq", irq, 1'b0);
  endtask
  task t_err;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h1c, 32'hff, r);
    chk("wr_err", r, 2'h2);
    rdr(8'h1c, d, r);
    chk("rd_err", r, 2'h2);
    chk("rd_zero", d, 32'h0);
    w(`SAS_OFS_RES_LOW, 32'h0);
    rchk("res_ro", `SAS_OFS_RES_LOW, {24'h0, level[7][7:0]});
    // A write with the low byte lane off must leave the register alone
    ws <= 4'h0;
    w(`SAS_OFS_PIN_SEL, 32'h0);
    ws <= 4'hf;
    rchk("strb_off", `SAS_OFS_PIN_SEL, 32'h5a);
  endtask

  task results;
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 8; i++)
      level[i] = (i == 0) ? 10'h0 : (i == 7) ? 10'h3ff : 10'(i * 131);
    repeat (6) @(posedge ref_clk);
    nrst <= 1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_fields();
    // Divided clocks run far faster than a real converter allows; the ideal model copes
    for (int k = 0; k < 8; k++)
      t_conv(k);
    t_irq();
    t_abort();
    t_err();
    results();
  end
  initial
  begin
    #500000;
    err_count++;
    results();
  end
endmodule
bind sas_top sas_props sas_props_i (.ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_hold, .irq);
